// >>> wdog_pkg.sv
// constants shared by the watchdog pair: register offsets, reset values, timing
// assumes a 125 MHz core clock and a 25 MHz base tick derived from it
package wdog_pkg;

  // register offsets, byte addresses on the local register port
  localparam logic [11:0] TICK_DIVIDER_OFS  = 12'h400;
  localparam logic [11:0] LOCAL_COUNT_OFS   = 12'h410;
  localparam logic [11:0] BUFFER_COUNT_OFS  = 12'h420;
  localparam logic [11:0] SAFE_VALUE_OFS    = 12'h430;
  localparam logic [11:0] STATUS_OFS        = 12'h440;

  // status field positions
  localparam int STAT_LOCAL_EXPIRED_BIT  = 0;
  localparam int STAT_BUFFER_EXPIRED_BIT = 1;

  // reset values: give the usual 100 ms timeout
  localparam logic [15:0] TICK_DIVIDER_RST  = 16'h09c2;  // 2498
  localparam logic [15:0] LOCAL_COUNT_RST   = 16'h03e8;  // 1000
  localparam logic [15:0] BUFFER_COUNT_RST  = 16'h03e8;  // 1000
  localparam logic [15:0] SAFE_VALUE_RST    = 16'h0000;  // outputs off

  // extra base periods added to the divider per tick
  localparam logic [16:0] TICK_DIVIDER_ADD  = 17'h00002;

  // timing: base period and core clock period in picoseconds
  localparam int BASE_PERIOD_PS = 40000;
  localparam int CLK_PERIOD_PS  = 8000;
  // whole core cycles per base period, rounded up
  localparam int BASE_CYCLES    = (BASE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // watchdog states
  typedef enum logic [1:0] {
    WD_RUNNING  = 2'b00,
    WD_EXPIRED  = 2'b01,
    WD_DISABLED = 2'b10
  } wd_state_type;

endpackage

// >>> wd_timer.sv
// one timeout counter of the pair, counting shared watchdog ticks
// assumes tick_i and restart_i are single-cycle pulses in the core clock domain
`timescale 1ns/1ps
module wd_timer #(
  parameter int COUNT_W = 16
) (
  // clock, reset and enable
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               ce_i,
  // control
  input  wire logic               tick_i,
  input  wire logic               restart_i,
  input  wire logic [COUNT_W-1:0] count_i,
  // status
  output logic                    expired_o
);

  initial begin
    if (COUNT_W < 1) $error("wd_timer: COUNT_W must be at least 1");
  end

  wdog_pkg::wd_state_type state;       // current watchdog state
  wdog_pkg::wd_state_type next_state;  // next watchdog state
  logic [COUNT_W-1:0]     remain;      // ticks left before firing
  logic [COUNT_W-1:0]     next_remain;

  // next state: restart beats a tick landing in the same cycle
  always_comb begin
    next_state  = state;
    next_remain = remain;
    case (state)
      wdog_pkg::WD_RUNNING: begin
        if (count_i == '0) begin
          next_state = wdog_pkg::WD_DISABLED;
        end else if (restart_i) begin
          next_remain = count_i;
        end else if (tick_i) begin
          if (remain <= COUNT_W'(1)) begin
            next_state = wdog_pkg::WD_EXPIRED;
          end else begin
            next_remain = remain - COUNT_W'(1);
          end
        end
      end
      wdog_pkg::WD_EXPIRED: begin
        // stays fired until valid traffic comes back or the count is set to zero
        if (count_i == '0) begin
          next_state = wdog_pkg::WD_DISABLED;
        end else if (restart_i) begin
          next_state  = wdog_pkg::WD_RUNNING;
          next_remain = count_i;
        end
      end
      wdog_pkg::WD_DISABLED: begin
        // a nonzero count re-arms with a full timeout
        if (count_i != '0) begin
          next_state  = wdog_pkg::WD_RUNNING;
          next_remain = count_i;
        end
      end
      default: begin
        next_state = wdog_pkg::WD_RUNNING;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state  <= wdog_pkg::WD_DISABLED;
      remain <= '0;
    end else if (ce_i) begin
      state  <= next_state;
      remain <= next_remain;
    end
  end

  assign expired_o = (state == wdog_pkg::WD_EXPIRED);

endmodule // wd_timer

// >>> comm_loss_watchdog_pair.sv
// pair of communication-loss watchdogs with shared tick divider and safe-output forcing
// assumes a synchronous register port and single-cycle access pulses from both sides
`timescale 1ns/1ps
module comm_loss_watchdog_pair #(
  parameter int OUT_W   = 16,
  parameter int COUNT_W = 16
) (
  // clock, reset, enable
  input  wire logic             CORE_CLK_I,
  input  wire logic             RST_B_I,
  input  wire logic             CE_I,
  // register port
  input  wire logic [11:0]      REG_ADDR_I,
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  input  wire logic [15:0]      REG_WDATA_I,
  output logic      [15:0]      REG_RDATA_O,
  // traffic events
  input  wire logic             NET_PD_ACCESS_I,
  input  wire logic             LOCAL_PD_ACCESS_I,
  // communication state passes through untouched
  input  wire logic [3:0]       COMM_STATE_I,
  output logic      [3:0]       COMM_STATE_O,
  // process outputs
  input  wire logic [OUT_W-1:0] PD_OUT_I,
  output logic      [OUT_W-1:0] PD_OUT_O,
  // status
  output logic                  BUFFER_EXPIRED_O,
  output logic                  LOCAL_EXPIRED_O
);

  initial begin
    if (OUT_W < 1 || OUT_W > 16) $error("OUT_W must be 1..16");
    if (COUNT_W != 16) $error("COUNT_W must be 16 to match the registers");
  end

  localparam logic [2:0] BASE_LAST = 3'(wdog_pkg::BASE_CYCLES - 1);

  // decode of a register offset, shared by write and read paths
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // registers and their next values
  logic [15:0]      tick_divider;                  // shared tick length
  logic [15:0]      local_interface_timeout_count;  // local watchdog count
  logic [15:0]      buffer_timeout_count;          // buffer watchdog count
  logic [15:0]      safe_value;                    // value forced on expiry
  logic [15:0]      next_tick_divider;
  logic [15:0]      next_local_count;
  logic [15:0]      next_buffer_count;
  logic [15:0]      next_safe_value;
  logic [15:0]      next_rdata;

  // tick generation
  logic [2:0]       base_cnt;     // core cycles within a base period
  logic [16:0]      tick_cnt;     // base periods within a tick
  logic [2:0]       next_base_cnt;
  logic [16:0]      next_tick_cnt;
  logic             base_pulse;
  logic             tick;

  // watchdog results and output stage
  logic [1:0]       expired;      // bit 0 local, bit 1 buffer
  logic [OUT_W-1:0] next_pd_out;
  logic [3:0]       next_comm_state;

  // register writes; a register not written keeps its value
  always_comb begin
    next_tick_divider = tick_divider;
    next_local_count  = local_interface_timeout_count;
    next_buffer_count = buffer_timeout_count;
    next_safe_value   = safe_value;
    if (REG_WR_I) begin
      if (hit(REG_ADDR_I, wdog_pkg::TICK_DIVIDER_OFS)) next_tick_divider = REG_WDATA_I;
      if (hit(REG_ADDR_I, wdog_pkg::LOCAL_COUNT_OFS))  next_local_count  = REG_WDATA_I;
      if (hit(REG_ADDR_I, wdog_pkg::BUFFER_COUNT_OFS)) next_buffer_count = REG_WDATA_I;
      if (hit(REG_ADDR_I, wdog_pkg::SAFE_VALUE_OFS))   next_safe_value   = REG_WDATA_I;
    end
  end

  // read mux; unmapped offsets read zero, data valid one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (hit(REG_ADDR_I, wdog_pkg::TICK_DIVIDER_OFS)) next_rdata = tick_divider;
    if (hit(REG_ADDR_I, wdog_pkg::LOCAL_COUNT_OFS))  next_rdata = local_interface_timeout_count;
    if (hit(REG_ADDR_I, wdog_pkg::BUFFER_COUNT_OFS)) next_rdata = buffer_timeout_count;
    if (hit(REG_ADDR_I, wdog_pkg::SAFE_VALUE_OFS))   next_rdata = safe_value;
    if (hit(REG_ADDR_I, wdog_pkg::STATUS_OFS)) begin
      next_rdata[wdog_pkg::STAT_LOCAL_EXPIRED_BIT]  = expired[0];
      next_rdata[wdog_pkg::STAT_BUFFER_EXPIRED_BIT] = expired[1];
    end
    if (!REG_RD_I) next_rdata = REG_RDATA_O;
  end

  // register file flops; contents hold until software rewrites them or reset reloads the defaults
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tick_divider                  <= wdog_pkg::TICK_DIVIDER_RST;
      local_interface_timeout_count <= wdog_pkg::LOCAL_COUNT_RST;
      buffer_timeout_count          <= wdog_pkg::BUFFER_COUNT_RST;
      safe_value                    <= wdog_pkg::SAFE_VALUE_RST;
      REG_RDATA_O                   <= 16'h0000;
    end else if (CE_I) begin
      tick_divider                  <= next_tick_divider;
      local_interface_timeout_count <= next_local_count;
      buffer_timeout_count          <= next_buffer_count;
      safe_value                    <= next_safe_value;
      REG_RDATA_O                   <= next_rdata;
    end
  end

  // base period and tick divider; 17-bit tick counter reaches 65537 periods,
  // so with a 16-bit count the longest timeout is near 172 s
  always_comb begin
    base_pulse    = (base_cnt == BASE_LAST);
    next_base_cnt = base_pulse ? 3'h0 : base_cnt + 3'h1;
    tick          = base_pulse && (tick_cnt >= {1'b0, tick_divider} + wdog_pkg::TICK_DIVIDER_ADD - 17'h00001);
    next_tick_cnt = tick_cnt;
    if (base_pulse) next_tick_cnt = tick ? 17'h00000 : tick_cnt + 17'h00001;
  end

  // divider flops; free running, so a restart sees up to one tick of jitter
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      base_cnt <= 3'h0;
      tick_cnt <= 17'h00000;
    end else if (CE_I) begin
      base_cnt <= next_base_cnt;
      tick_cnt <= next_tick_cnt;
    end
  end

  // the two timers: index 0 local side, index 1 network side
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_wd
      wd_timer #(
        .COUNT_W (COUNT_W)
      ) u_timer (
        .clk_i     (CORE_CLK_I),
        .rst_b_i   (RST_B_I),
        .ce_i      (CE_I),
        .tick_i    (tick),
        .restart_i ((g == 0) ? LOCAL_PD_ACCESS_I : NET_PD_ACCESS_I),
        .count_i   ((g == 0) ? local_interface_timeout_count : buffer_timeout_count),
        .expired_o (expired[g])
      );
    end
  endgenerate

  // output stage: either watchdog firing forces the safe value
  always_comb begin
    next_pd_out     = (|expired) ? safe_value[OUT_W-1:0] : PD_OUT_I;
    next_comm_state = COMM_STATE_I;
  end

  // output flops
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PD_OUT_O         <= '0;
      COMM_STATE_O     <= 4'h0;
      BUFFER_EXPIRED_O <= 1'b0;
      LOCAL_EXPIRED_O  <= 1'b0;
    end else if (CE_I) begin
      PD_OUT_O         <= next_pd_out;
      COMM_STATE_O     <= next_comm_state;
      BUFFER_EXPIRED_O <= expired[1];
      LOCAL_EXPIRED_O  <= expired[0];
    end
  end

endmodule // comm_loss_watchdog_pair

// >>> wd_pair_checker_assertions.sv
// concurrent checks on the ports of the watchdog pair
// assumes one core clock and shadows registers from the write strobes
`timescale 1ns/1ps
module wd_pair_checker #(
  parameter int OUT_W   = 16,
  parameter int COUNT_W = 16
) (
  // clock, reset, enable
  input wire logic             CORE_CLK_I,
  input wire logic             RST_B_I,
  input wire logic             CE_I,
  // register writes
  input wire logic [11:0]      REG_ADDR_I,
  input wire logic             REG_WR_I,
  input wire logic [15:0]      REG_WDATA_I,
  // traffic and outputs
  input wire logic             NET_PD_ACCESS_I,
  input wire logic             LOCAL_PD_ACCESS_I,
  input wire logic [3:0]       COMM_STATE_I,
  input wire logic [3:0]       COMM_STATE_O,
  input wire logic [OUT_W-1:0] PD_OUT_I,
  input wire logic [OUT_W-1:0] PD_OUT_O,
  input wire logic             BUFFER_EXPIRED_O,
  input wire logic             LOCAL_EXPIRED_O
);
  logic [15:0] div_s, cnt_s, lcnt_s, safe_s;  // shadow registers
  logic [39:0] quiet_cyc;                    // cycles since network access
  logic        valid;                        // no write since that access
  logic [39:0] tick, span;                   // tick and full timeout
  assign tick = (40'(div_s) + 40'h2) * 40'(wdog_pkg::BASE_CYCLES);
  assign span = tick * 40'(cnt_s);
  // shadows follow writes; any write voids timing checks till next access
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      div_s     <= wdog_pkg::TICK_DIVIDER_RST;
      cnt_s     <= wdog_pkg::BUFFER_COUNT_RST;
      lcnt_s    <= wdog_pkg::LOCAL_COUNT_RST;
      safe_s    <= wdog_pkg::SAFE_VALUE_RST;
      quiet_cyc <= 40'h0;
      valid     <= 1'b1;
    end else if (CE_I) begin
      if (REG_WR_I && REG_ADDR_I == wdog_pkg::TICK_DIVIDER_OFS) div_s <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == wdog_pkg::BUFFER_COUNT_OFS) cnt_s <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == wdog_pkg::LOCAL_COUNT_OFS) lcnt_s <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == wdog_pkg::SAFE_VALUE_OFS) safe_s <= REG_WDATA_I;
      quiet_cyc <= NET_PD_ACCESS_I ? 40'h0 : quiet_cyc + 40'h1;
      valid     <= (NET_PD_ACCESS_I | valid) & !REG_WR_I;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence net_hit; NET_PD_ACCESS_I && CE_I; endsequence
  sequence loc_hit; LOCAL_PD_ACCESS_I && CE_I; endsequence
  sequence quiet; !NET_PD_ACCESS_I && !REG_WR_I && CE_I; endsequence
  AST_STATE_KEPT: assert property (CE_I |=> COMM_STATE_O == $past(COMM_STATE_I))
    else $error("comm state altered");
  AST_BUF_CLEAR: assert property (net_hit ##1 (CE_I && !REG_WR_I && cnt_s > 16'h1) |=> !BUFFER_EXPIRED_O)
    else $error("buffer flag not cleared");
  AST_LOC_CLEAR: assert property (loc_hit ##1 (CE_I && !REG_WR_I && lcnt_s > 16'h1) |=> !LOCAL_EXPIRED_O)
    else $error("local flag not cleared");
  AST_BUF_HOLD: assert property (quiet ##1 quiet ##0 BUFFER_EXPIRED_O |=> BUFFER_EXPIRED_O)
    else $error("buffer flag dropped");
  AST_SAFE_OUT: assert property ((BUFFER_EXPIRED_O || LOCAL_EXPIRED_O) && $past(CE_I)
    |-> PD_OUT_O == $past(safe_s[OUT_W-1:0]))
    else $error("outputs not safe");
  AST_PASS_OUT: assert property (!BUFFER_EXPIRED_O && !LOCAL_EXPIRED_O && $past(CE_I) && $past(RST_B_I)
    |-> PD_OUT_O == $past(PD_OUT_I))
    else $error("outputs not passed");
  // a zero count needs two edges (timer state, then flag flop) before the flag drops
  AST_ZERO_OFF: assert property (cnt_s == 16'h0 && $past(cnt_s) == 16'h0 && $past(cnt_s, 2) == 16'h0
    |-> !BUFFER_EXPIRED_O)
    else $error("disabled watchdog fired");
  AST_BUF_LATE: assert property (valid && cnt_s != 16'h0 && quiet_cyc > span + 40'h3 |-> BUFFER_EXPIRED_O)
    else $error("buffer watchdog late");
  AST_BUF_EARLY: assert property ($rose(BUFFER_EXPIRED_O) && valid |-> quiet_cyc + tick >= span + 40'h1)
    else $error("buffer watchdog early");
endmodule // wd_pair_checker
bind comm_loss_watchdog_pair wd_pair_checker #(.OUT_W(OUT_W), .COUNT_W(COUNT_W)) wd_pair_checker_inst (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
  .REG_WDATA_I(REG_WDATA_I), .NET_PD_ACCESS_I(NET_PD_ACCESS_I), .LOCAL_PD_ACCESS_I(LOCAL_PD_ACCESS_I),
  .COMM_STATE_I(COMM_STATE_I), .COMM_STATE_O(COMM_STATE_O), .PD_OUT_I(PD_OUT_I), .PD_OUT_O(PD_OUT_O),
  .BUFFER_EXPIRED_O(BUFFER_EXPIRED_O), .LOCAL_EXPIRED_O(LOCAL_EXPIRED_O));

// >>> wd_traffic_model.sv
// traffic sources: network master and local processor access pulses
// assumes the bench sets enables and the spacing of pulses
`timescale 1ns/1ps
module wd_traffic_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // behaviour control
  input  wire logic       net_en_i,
  input  wire logic       loc_en_i,
  input  wire logic [7:0] gap_i,
  // access pulses
  output logic            net_pd_access_o,
  output logic            local_pd_access_o
);
  logic [7:0] cnt;  // free phase counter, period gap plus one
  // stopped sources keep their line low; >= survives a shrinking gap
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt               <= 8'h00;
      net_pd_access_o   <= 1'b0;
      local_pd_access_o <= 1'b0;
    end else begin
      cnt               <= (cnt >= gap_i) ? 8'h00 : cnt + 8'h01;
      net_pd_access_o   <= net_en_i && cnt == 8'h00;
      local_pd_access_o <= loc_en_i && cnt == 8'h03;
    end
  end
endmodule // wd_traffic_model

// >>> comm_loss_watchdog_pair_tb.sv
// bench for the watchdog pair: register reads queued, flags sampled
// assumes divider 0 gives 10-cycle ticks at 125 MHz
`timescale 1ns/1ps
module comm_loss_watchdog_pair_tb;
  logic        CORE_CLK_I = 1'b0;
  logic        RST_B_I = 1'b0;
  logic        CE_I = 1'b1;
  logic [11:0] REG_ADDR_I = 12'h000;
  logic        REG_WR_I = 1'b0, REG_RD_I = 1'b0, pend = 1'b0;
  logic [15:0] REG_WDATA_I = 16'h0000, REG_RDATA_O, PD_OUT_I = 16'h0000, PD_OUT_O;
  logic [3:0]  COMM_STATE_I = 4'h0, COMM_STATE_O;
  logic        NET_PD_ACCESS_I, LOCAL_PD_ACCESS_I, BUFFER_EXPIRED_O, LOCAL_EXPIRED_O;
  logic        net_en = 1'b0, loc_en = 1'b0;  // traffic sources on
  logic [7:0]  gap = 8'h12;                   // pulse spacing
  logic [15:0] expq[$];                       // expected read data
  int          mismatches = 0, compares = 0, seed = 50977;
  always #4 CORE_CLK_I = ~CORE_CLK_I;
  // random process data and state every cycle
  always @(posedge CORE_CLK_I) begin
    PD_OUT_I     <= 16'($random(seed));
    COMM_STATE_I <= 4'($random(seed));
  end
  comm_loss_watchdog_pair comm_loss_watchdog_pair_inst (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
    .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .NET_PD_ACCESS_I(NET_PD_ACCESS_I),
    .LOCAL_PD_ACCESS_I(LOCAL_PD_ACCESS_I), .COMM_STATE_I(COMM_STATE_I), .COMM_STATE_O(COMM_STATE_O),
    .PD_OUT_I(PD_OUT_I), .PD_OUT_O(PD_OUT_O), .BUFFER_EXPIRED_O(BUFFER_EXPIRED_O),
    .LOCAL_EXPIRED_O(LOCAL_EXPIRED_O));
  wd_traffic_model wd_traffic_model_inst (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I), .net_en_i(net_en),
    .loc_en_i(loc_en), .gap_i(gap), .net_pd_access_o(NET_PD_ACCESS_I), .local_pd_access_o(LOCAL_PD_ACCESS_I));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge CORE_CLK_I);
    REG_ADDR_I  <= a;
    REG_WDATA_I <= d;
    REG_WR_I    <= 1'b1;
    @(posedge CORE_CLK_I);
    REG_WR_I    <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge CORE_CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I   <= 1'b1;
    expq.push_back(e);
    @(posedge CORE_CLK_I);
    REG_RD_I   <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CORE_CLK_I);
  endtask
  task automatic flags(input logic [1:0] e);
    @(negedge CORE_CLK_I);
    chk({14'h0, BUFFER_EXPIRED_O, LOCAL_EXPIRED_O}, {14'h0, e});
  endtask
  // read data shows by the falling edge after the taking edge
  always @(posedge CORE_CLK_I) pend <= REG_RD_I;
  always @(negedge CORE_CLK_I) begin
    if (pend) chk(REG_RDATA_O, expq.pop_front());
  end
  // hang guard, far beyond the planned run
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial begin
    wait_cyc(16);
    RST_B_I <= 1'b1;
    rd(wdog_pkg::TICK_DIVIDER_OFS, 16'h09c2);
    rd(wdog_pkg::BUFFER_COUNT_OFS, 16'h03e8);
    rd(12'h7f0, 16'h0000);
    wr(wdog_pkg::STATUS_OFS, 16'hffff);
    rd(wdog_pkg::STATUS_OFS, 16'h0000);
    wr(wdog_pkg::TICK_DIVIDER_OFS, 16'h0000);
    wr(wdog_pkg::BUFFER_COUNT_OFS, 16'h0003);
    rd(wdog_pkg::LOCAL_COUNT_OFS, 16'h03e8);
    wr(wdog_pkg::LOCAL_COUNT_OFS, 16'h0004);
    wr(wdog_pkg::SAFE_VALUE_OFS, 16'ha5a5);
    rd(wdog_pkg::BUFFER_COUNT_OFS, 16'h0003);
    net_en <= 1'b1;
    loc_en <= 1'b1;
    wait_cyc(200);
    flags(2'b00);
    net_en <= 1'b0;
    wait_cyc(45);
    flags(2'b10);
    rd(wdog_pkg::STATUS_OFS, 16'h0002);
    wait_cyc(60);
    flags(2'b10);
    net_en <= 1'b1;
    wait_cyc(30);
    flags(2'b00);
    loc_en <= 1'b0;
    wait_cyc(55);
    flags(2'b01);
    loc_en <= 1'b1;
    wait_cyc(30);
    flags(2'b00);
    wr(wdog_pkg::BUFFER_COUNT_OFS, 16'h0000);
    net_en <= 1'b0;
    wait_cyc(150);
    flags(2'b00);
    wr(wdog_pkg::BUFFER_COUNT_OFS, 16'h0003);
    wr(wdog_pkg::TICK_DIVIDER_OFS, 16'h0004);
    gap <= 8'h32;
    net_en <= 1'b1;
    wait_cyc(200);
    flags(2'b00);
    gap <= 8'h08;
    wait_cyc(30);
    net_en <= 1'b0;
    loc_en <= 1'b0;
    wait_cyc(35);
    flags(2'b00);
    wait_cyc(100);
    flags(2'b11);
    rd(wdog_pkg::STATUS_OFS, 16'h0003);
    // a low enable must freeze flags and forced outputs
    CE_I <= 1'b0;
    wait_cyc(20);
    flags(2'b11);
    chk(PD_OUT_O, 16'ha5a5);
    @(posedge CORE_CLK_I);
    CE_I <= 1'b1;
    RST_B_I <= 1'b0;
    wait_cyc(3);
    flags(2'b00);
    @(posedge CORE_CLK_I);
    RST_B_I <= 1'b1;
    rd(wdog_pkg::TICK_DIVIDER_OFS, 16'h09c2);
    wait_cyc(4);
    stop_test();
  end
endmodule // comm_loss_watchdog_pair_tb
